// ==== rtl/psc_halt_idle_ctrl.sv ====
`default_nettype none
module psc_halt_idle_ctrl
  import psc_pkg::*;
#(
  parameter int WAKE_W = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // core software controls
  input  wire logic              halt_request,
  input  wire logic              idle_request,
  input  wire logic              halt_disable_option,
  input  wire logic              startup_delay_select,
  input  wire logic              pmc_write,
  input  wire logic [7:0]        pmc_wdata,
  input  wire logic              pending_clear,
  input  wire logic              idle_tick_irq_enable,
  // pins
  input  wire logic [WAKE_W-1:0] wake_pins,
  input  wire logic [WAKE_W-1:0] wake_enable,
  input  wire logic [WAKE_W-1:0] wake_rising,
  input  wire logic              osc_amp_ok_pin,
  input  wire logic              slow_clk_pin,
  // core side status
  output logic                   core_clk_enable,
  output logic                   fetch_restart,
  output logic [15:0]            fetch_address,
  output logic                   halted,
  output logic                   idling,
  output logic                   starting,
  output logic                   idle_exit,
  output logic                   self_reset,
  // idle tick
  output logic                   idle_tick_pending,
  output logic                   idle_tick_irq,
  // mode register
  output logic [7:0]             power_mode_control_reg,
  output logic                   slow_osc_enable,
  output logic                   fast_osc_enable,
  output logic                   tick_timer_slow_clock_select,
  output logic                   core_clock_source_select
);

  // ============================================================
  // clock ticks and synchronised pins
  logic              inst_tick;
  logic [WAKE_W-1:0] wake_rise;
  logic [WAKE_W-1:0] wake_fall;
  logic              amp_ok;
  logic              slow_rise;
  logic              unused_slow_level;
  logic              unused_amp_rise;

  psc_inst_div #(
    .DIV (INST_DIV)
  ) u_div (
    .clk    (clk),
    .arst_n (arst_n),
    .tick   (inst_tick)
  );

  psc_pin_sync #(
    .W (WAKE_W)
  ) u_wake_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .pin    (wake_pins),
    .level  (),
    .rise   (wake_rise),
    .fall   (wake_fall)
  );

  psc_pin_sync #(
    .W (2)
  ) u_osc_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .pin    ({slow_clk_pin, osc_amp_ok_pin}),
    .level  ({unused_slow_level, amp_ok}),
    .rise   ({slow_rise, unused_amp_rise}),
    .fall   ()
  );

  logic wake_event;
  assign wake_event = |(wake_enable & ((wake_rise & wake_rising) | (wake_fall & ~wake_rising)));

  // ============================================================
  // power-mode control register
  psc_pmc_t pmc_reg;
  logic     mode_illegal;
  logic     self_reset_reg;

  always_comb
  begin
    mode_illegal = 1'b0;
    if (pmc_write)
    begin
      if (pmc_wdata[7:4] != MODE_HIGH && pmc_wdata[7:4] != MODE_HIGH_DUAL &&
          pmc_wdata[7:4] != MODE_DUAL && pmc_wdata[7:4] != MODE_DUAL_LOW &&
          pmc_wdata[7:4] != MODE_LOW)
        mode_illegal = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pmc_reg <= psc_pmc_t'(PMC_RESET_VAL);
    else if (mode_illegal)
      pmc_reg <= psc_pmc_t'(PMC_RESET_VAL);
    else if (pmc_write)
      pmc_reg <= psc_pmc_t'({pmc_wdata[7:4], 1'b0, pmc_wdata[2:0]});
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      self_reset_reg <= 1'b0;
    else
      self_reset_reg <= mode_illegal;
  end

  // ============================================================
  // power-save state machine
  psc_state_t       state_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic             startup_done;
  logic             tap_toggle;
  logic             idle_exit_reg;
  logic             restart_reg;

  // startup_delay_select has no effect: the wake delay is always inserted
  assign startup_done = (state_reg == PSC_STARTUP) && inst_tick && amp_ok &&
                        (timer_reg == 16'h0001);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state_reg <= PSC_RUN;
    else if (mode_illegal)
      state_reg <= PSC_RUN;
    else
    begin
      case (state_reg)
        PSC_RUN:
        begin
          if (halt_request && !halt_disable_option)
            state_reg <= PSC_HALT;
          else if (idle_request)
            state_reg <= PSC_IDLE;
        end
        PSC_HALT:
        begin
          if (wake_event)
            state_reg <= PSC_STARTUP;
        end
        PSC_STARTUP:
        begin
          if (startup_done)
            state_reg <= PSC_RUN;
        end
        PSC_IDLE:
        begin
          if (tap_toggle || wake_event)
            state_reg <= PSC_RUN;
        end
        default:
          state_reg <= PSC_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      idle_exit_reg <= 1'b0;
    else
      idle_exit_reg <= (state_reg == PSC_IDLE) && (tap_toggle || wake_event);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      restart_reg <= 1'b1;
    else
      restart_reg <= mode_illegal;
  end

  // ============================================================
  // idle timer: counts in every state but HALT, loaded on a halt wake, hidden from software
  logic             timer_step;
  logic [TIMER_W-1:0] timer_next;
  logic [4:0]       tap_bit;
  logic [TIMER_W-1:0] tap_mask;

  // timer source: amplitude-gated instruction ticks in STARTUP, else slow-clock edges when slow select is set, else instruction ticks;
  // the fast clock is stopped in HALT so nothing counts there
  always_comb
  begin
    timer_step = 1'b0;
    if (state_reg == PSC_STARTUP)
      timer_step = inst_tick && amp_ok;
    else if (state_reg != PSC_HALT)
    begin
      if (pmc_reg.tick_timer_slow_clock_select)
        timer_step = slow_rise;
      else
        timer_step = inst_tick;
    end
  end

  assign timer_next = timer_reg - 16'h0001;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      timer_reg <= '0;
    else if (state_reg == PSC_HALT && wake_event)
      timer_reg <= STARTUP_LOAD;
    else if (timer_step)
      timer_reg <= timer_next;
  end

  // codes above the 64k entry fall back to the 64k tap
  assign tap_bit = (pmc_reg.window_tap_select > TAP_MAX_SEL) ? 5'(TAP_BASE_BIT + 4)
                 : 5'(TAP_BASE_BIT + 32'(pmc_reg.window_tap_select));
  // a decrement flips the tap bit when all bits below it are zero; the 64k tap is the borrow out
  assign tap_mask = TIMER_W'((32'h1 << tap_bit) - 32'h1);

  assign tap_toggle = timer_step && (state_reg != PSC_STARTUP) &&
                      ((timer_reg & tap_mask) == '0);

  // ============================================================
  // pending flag and interrupt
  logic pending_reg;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pending_reg <= 1'b0;
    else if (tap_toggle)
      pending_reg <= 1'b1; // set wins over a same-cycle clear
    else if (pending_clear)
      pending_reg <= 1'b0;
  end

  // ============================================================
  // outputs
  assign core_clk_enable              = (state_reg == PSC_RUN);
  assign fetch_restart                = restart_reg;
  assign fetch_address                = RESET_VECTOR;
  assign halted                       = (state_reg == PSC_HALT);
  assign idling                       = (state_reg == PSC_IDLE);
  assign starting                     = (state_reg == PSC_STARTUP);
  assign idle_exit                    = idle_exit_reg;
  assign self_reset                   = self_reset_reg;
  assign idle_tick_pending            = pending_reg;
  assign idle_tick_irq                = pending_reg && idle_tick_irq_enable;
  assign power_mode_control_reg       = pmc_reg;
  assign slow_osc_enable              = pmc_reg.slow_osc_enable;
  assign fast_osc_enable              = pmc_reg.fast_osc_enable;
  assign tick_timer_slow_clock_select = pmc_reg.tick_timer_slow_clock_select;
  assign core_clock_source_select     = pmc_reg.core_clock_source_select;

  // ============================================================
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  chk_halt_disabled: assert property (
    state_reg == PSC_RUN && halt_disable_option && !mode_illegal |=> state_reg != PSC_HALT)
    else $error("halt entered while disabled");

  chk_halt_entry: assert property (
    state_reg == PSC_RUN && halt_request && !halt_disable_option && !mode_illegal |=> halted)
    else $error("halt request not taken");

  chk_idle_entry: assert property (
    state_reg == PSC_RUN && idle_request && !halt_request && !mode_illegal |=> idling)
    else $error("idle request not taken");

  chk_wake_load: assert property (
    halted && wake_event && !mode_illegal |=> starting && timer_reg == STARTUP_LOAD)
    else $error("wake did not load start-up count");

  chk_startup_gate: assert property (
    starting && !amp_ok |=> $stable(timer_reg))
    else $error("start-up count moved without amplitude");

  chk_startup_release: assert property (
    starting && timer_reg == 16'h0001 && inst_tick && amp_ok |=> core_clk_enable)
    else $error("core clock not released at underflow");

  chk_clk_gated: assert property (
    (halted || idling || starting) |-> !core_clk_enable)
    else $error("core clock running while stopped");

  chk_idle_exit: assert property (
    idling && tap_toggle && !mode_illegal |=> !idling && pending_reg && idle_exit)
    else $error("tap toggle did not end idle");

  chk_pending_set: assert property (
    tap_toggle && pending_clear |=> pending_reg)
    else $error("pending lost against clear");

  chk_irq_gate: assert property (
    idle_tick_irq |-> pending_reg && idle_tick_irq_enable)
    else $error("interrupt not gated by enable");

  chk_tick_rate: assert property (
    inst_tick |=> !inst_tick [*4] ##1 inst_tick)
    else $error("instruction tick not one in five");

  chk_illegal_mode: assert property (
    mode_illegal |=> self_reset && pmc_reg == psc_pmc_t'(PMC_RESET_VAL) ##1 !self_reset)
    else $error("illegal mode not reset");

  // helper: cycles spent in the start-up wait, saturating
  logic [11:0] start_cyc_reg;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      start_cyc_reg <= 12'h000;
    else if (state_reg != PSC_STARTUP)
      start_cyc_reg <= 12'h000;
    else if (start_cyc_reg != 12'hfff)
      start_cyc_reg <= start_cyc_reg + 12'h001;
  end

  cov_halt_wake: cover property (starting && start_cyc_reg >= 12'h500 ##1 core_clk_enable);
  cov_idle_tick: cover property (idling ##[1:1000] idle_exit);
  cov_idle_wake: cover property (idling && wake_event && !tap_toggle);
  cov_dual_clock: cover property (pmc_reg[7:4] == MODE_DUAL && tap_toggle);

endmodule : psc_halt_idle_ctrl
`default_nettype wire

// ==== rtl/psc_inst_div.sv ====
`default_nettype none
// ============================================================
// instruction-cycle tick: one pulse every DIV oscillator clocks
module psc_inst_div
  import psc_pkg::*;
#(
  parameter int DIV = INST_DIV
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // tick out
  output logic      tick
);

  logic [7:0] cnt_reg;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_reg <= 8'h00;
    else if (cnt_reg == 8'(DIV - 1))
      cnt_reg <= 8'h00;
    else
      cnt_reg <= cnt_reg + 8'h01;
  end

  assign tick = (cnt_reg == 8'(DIV - 1));

endmodule : psc_inst_div
`default_nettype wire

// ==== rtl/psc_pin_sync.sv ====
`default_nettype none
// ============================================================
// two-flop synchroniser with edge detect on the settled level
module psc_pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // pin side
  input  wire logic [W-1:0] pin,
  // synchronous side
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg;
  assign fall  = ~sync_reg & prev_reg;

endmodule : psc_pin_sync
`default_nettype wire

// ==== rtl/psc_pkg.sv ====
`default_nettype none
// ============================================================
// shared constants and types
package psc_pkg;

  // ============================================================
  // power-mode control register layout
  typedef struct packed {
    logic       slow_osc_enable;
    logic       fast_osc_enable;
    logic       tick_timer_slow_clock_select;
    logic       core_clock_source_select;
    logic       rsvd;
    logic [2:0] window_tap_select;
  } psc_pmc_t;

  localparam logic [7:0]  PMC_RESET_VAL   = 8'h40;
  // legal upper-nibble encodings: high, high/dual, dual, dual/low, low
  localparam logic [3:0]  MODE_HIGH       = 4'h4;
  localparam logic [3:0]  MODE_HIGH_DUAL  = 4'hc;
  localparam logic [3:0]  MODE_DUAL       = 4'he;
  localparam logic [3:0]  MODE_DUAL_LOW   = 4'hf;
  localparam logic [3:0]  MODE_LOW        = 4'hb;

  // ============================================================
  // timing and timer layout
  localparam int          INST_DIV        = 5;
  localparam int          TIMER_W         = 16;
  localparam logic [15:0] STARTUP_LOAD    = 16'h0100;
  localparam int          TAP_BASE_BIT    = 12;
  localparam logic [2:0]  TAP_MAX_SEL     = 3'h4;
  localparam logic [15:0] RESET_VECTOR    = 16'h0000;

  // ============================================================
  // controller states
  typedef enum logic [1:0] {
    PSC_RUN,
    PSC_HALT,
    PSC_STARTUP,
    PSC_IDLE
  } psc_state_t;

endpackage : psc_pkg
`default_nettype wire

// ==== tb/psc_pin_model.sv ====
`default_nettype none
// ============================================================
// wake pins, amplitude qualifier and low-speed oscillator
module psc_pin_model (
  // bench controls
  input  wire logic       slow_run,
  input  wire logic       amp_good,
  input  wire logic [7:0] wake_lvl,
  // pins
  output logic      [7:0] wake_pins,
  output logic            osc_amp_ok_pin,
  output logic            slow_clk_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // pins move a little after the bench, never on a clock edge
  assign #3 wake_pins = wake_lvl;
  assign #3 osc_amp_ok_pin = amp_good;
  // the slow oscillator stands still low while it is switched off
  initial slow_clk_pin = 1'b0;
  always
  begin
    #4517;
    slow_clk_pin = slow_run ? ~slow_clk_pin : 1'b0;
  end
endmodule : psc_pin_model
`default_nettype wire

// ==== tb/tb.sv ====
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import psc_pkg::*;
  logic        clk, arst_n, halt_request, idle_request, halt_disable_option;
  logic        startup_delay_select, pmc_write, pending_clear, idle_tick_irq_enable;
  logic        amp_good, osc_amp_ok_pin, slow_clk_pin;
  logic [7:0]  pmc_wdata, wake_lvl, wake_pins, wake_enable, wake_rising, power_mode_control_reg;
  logic        core_clk_enable, fetch_restart, halted, idling, starting, idle_exit, self_reset;
  logic        idle_tick_pending, idle_tick_irq, slow_osc_enable, fast_osc_enable;
  logic        tick_timer_slow_clock_select, core_clock_source_select;
  logic [15:0] fetch_address;
  int          err_total, n_compared, cyc, n, t1, t2;
  localparam logic [7:0] MODES [8] = '{8'hc0, 8'he0, 8'hf0, 8'hb0, 8'hf0, 8'he0, 8'hc0, 8'h40};

  psc_halt_idle_ctrl #(.WAKE_W(8)) dut (.clk(clk), .arst_n(arst_n), .halt_request(halt_request),
    .idle_request(idle_request), .halt_disable_option(halt_disable_option),
    .startup_delay_select(startup_delay_select), .pmc_write(pmc_write), .pmc_wdata(pmc_wdata),
    .pending_clear(pending_clear), .idle_tick_irq_enable(idle_tick_irq_enable), .wake_pins(wake_pins),
    .wake_enable(wake_enable), .wake_rising(wake_rising), .osc_amp_ok_pin(osc_amp_ok_pin),
    .slow_clk_pin(slow_clk_pin), .core_clk_enable(core_clk_enable), .fetch_restart(fetch_restart),
    .fetch_address(fetch_address), .halted(halted), .idling(idling), .starting(starting),
    .idle_exit(idle_exit), .self_reset(self_reset), .idle_tick_pending(idle_tick_pending),
    .idle_tick_irq(idle_tick_irq), .power_mode_control_reg(power_mode_control_reg),
    .slow_osc_enable(slow_osc_enable), .fast_osc_enable(fast_osc_enable),
    .tick_timer_slow_clock_select(tick_timer_slow_clock_select),
    .core_clock_source_select(core_clock_source_select));

  psc_pin_model model (.slow_run(slow_osc_enable), .amp_good(amp_good), .wake_lvl(wake_lvl),
    .wake_pins(wake_pins), .osc_amp_ok_pin(osc_amp_ok_pin), .slow_clk_pin(slow_clk_pin));

  // ============================================================
  // clock, cycle count, watchdog
  initial clk = 1'b0;
  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  initial
  begin
    // the tests need about 50k cycles
    repeat (90000) @(posedge clk);
    err_total++;
    give_verdict();
  end

  // ============================================================
  // access tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // sel 0 halt, 1 idle, 2 clear pending, else mode register write
  task automatic pulse(input int sel, input logic [7:0] d);
    @(negedge clk);
    halt_request = (sel == 0);
    idle_request = (sel == 1);
    pending_clear = (sel == 2);
    pmc_write = (sel > 2);
    pmc_wdata = d;
    @(negedge clk);
    {halt_request, idle_request, pending_clear, pmc_write} = 4'h0;
  endtask : pulse

  // sel 0 pending set, 1 starting, 2 core clock on, else idle over
  task automatic wait_until(input int sel, input int lim, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (!hit && cnt < lim)
    begin
      @(negedge clk);
      cnt++;
      case (sel)
        0: hit = (idle_tick_pending === 1'b1);
        1: hit = (starting === 1'b1);
        2: hit = (core_clk_enable === 1'b1);
        default: hit = (idling === 1'b0);
      endcase
    end
    if (!hit)
    begin
      err_total++;
      $display("unexpected wait %0d: expected hit seen none", sel);
    end
  endtask : wait_until

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // ============================================================
  // tests
  initial
  begin
    {err_total, n_compared, cyc} = '0;
    {arst_n, halt_request, idle_request, halt_disable_option, pmc_write, pending_clear} = '0;
    {idle_tick_irq_enable, pmc_wdata, wake_rising} = '0;
    startup_delay_select = 1'b1;
    amp_good = 1'b1;
    wake_enable = 8'h01;
    wake_lvl = 8'hfe;
    repeat (16) @(negedge clk);
    check("pmc_rst", power_mode_control_reg, PMC_RESET_VAL);
    check("restart", {fetch_restart, core_clk_enable}, 2'b11);
    check("fetch_addr", fetch_address, 16'h0000);
    arst_n = 1'b1;
    // first window is short since the timer starts at zero
    wait_until(0, 30, n);
    check("irq_gated", idle_tick_irq, 1'b0);
    idle_tick_irq_enable = 1'b1;
    @(negedge clk);
    check("irq_on", idle_tick_irq, 1'b1);
    halt_disable_option = 1'b1;
    pulse(0, 8'h00);
    check("halt_off", halted, 1'b0);
    halt_disable_option = 1'b0;
    startup_delay_select = 1'b0;
    pulse(0, 8'h00);
    check("halt", {halted, core_clk_enable}, 2'b10);
    // two instruction slots of no-ops follow the halt request
    repeat (10) @(negedge clk);
    wake_lvl = 8'hfd;
    repeat (8) @(negedge clk);
    wake_lvl = 8'hff;
    repeat (8) @(negedge clk);
    check("wrong_edge", halted, 1'b1);
    wake_lvl = 8'hfe;
    amp_good = 1'b0;
    wait_until(1, 10, n);
    check("start", {starting, halted, core_clk_enable}, 3'b100);
    repeat (200) @(negedge clk);
    amp_good = 1'b1;
    wait_until(2, 2000, n);
    check("start_len", (n + 200 >= 1470 && n + 200 <= 1490), 1'b1);
    check("start_len_div", (n + 200 > 256 * 5 + 190), 1'b1);
    check("start_amp", (n > 256 * 5 - 10), 1'b1);
    pulse(3, 8'h43);
    pulse(0, 8'h00);
    arst_n = 1'b0;
    @(negedge clk);
    check("rst_halt", {halted, fetch_restart, core_clk_enable}, 3'b011);
    check("rst_pmc", power_mode_control_reg, 8'h40);
    arst_n = 1'b1;
    @(negedge clk);
    check("restart_end", fetch_restart, 1'b0);
    pulse(2, 8'h00);
    wait_until(0, 25000, n);
    pulse(2, 8'h00);
    wait_until(0, 25000, n);
    t1 = cyc;
    check("run_tick", {idling, idle_exit}, 2'b00);
    pulse(2, 8'h00);
    pulse(1, 8'h00);
    check("idle_in", {idling, core_clk_enable}, 2'b10);
    wait_until(0, 25000, n);
    t2 = cyc;
    check("window_4k", t2 - t1, 16'd20480);
    check("idle_end", {idling, idle_tick_irq}, 2'b01);
    check("idle_exit", idle_exit, 1'b1);
    @(negedge clk);
    check("idle_exit_end", idle_exit, 1'b0);
    wake_lvl = 8'hff;
    pulse(2, 8'h00);
    pulse(1, 8'h00);
    wake_lvl = 8'hfe;
    wait_until(3, 10, n);
    check("wake_idle", {idling, idle_tick_pending}, 2'b00);
    // window changes can raise a stray pending, so mask then clear
    idle_tick_irq_enable = 1'b0;
    pulse(3, 8'h49);
    pulse(2, 8'h00);
    check("rsvd_bit", power_mode_control_reg, 8'h41);
    // high to dual, dual to low and back the way it came
    for (int i = 0; i < 8; i++)
    begin
      pulse(3, MODES[i]);
      check("mode_reg", power_mode_control_reg, MODES[i]);
      check("mode_bits", {slow_osc_enable, fast_osc_enable, tick_timer_slow_clock_select,
        core_clock_source_select, self_reset}, {MODES[i][7:4], 1'b0});
      if (i == 3)
        repeat (5000) @(negedge clk);
      if (i == 5)
        check("low_to_dual", core_clock_source_select, 1'b0);
    end
    pulse(3, 8'h45);
    pulse(3, 8'h80);
    n = self_reset;
    @(negedge clk);
    check("self_reset", {n[0], self_reset}, 2'b10);
    check("bad_mode", power_mode_control_reg, 8'h40);
    check("bad_state", {halted, idling, core_clk_enable}, 3'b001);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
